// ==== rtl/rawc_pkg.sv ====
// constants and types shared by the rtc alarm and watchdog control block
package rawc_pkg;
    // register addresses
    localparam logic [4:0] ADDR_SEC = 5'h0_0;
    localparam logic [4:0] ADDR_MIN = 5'h0_1;
    localparam logic [4:0] ADDR_HOUR = 5'h0_2;
    localparam logic [4:0] ADDR_DAY = 5'h0_3;
    localparam logic [4:0] ADDR_DATE = 5'h0_4;
    localparam logic [4:0] ADDR_AL_SEC = 5'h0_8;
    localparam logic [4:0] ADDR_AL_MIN = 5'h0_9;
    localparam logic [4:0] ADDR_AL_HOUR = 5'h0_A;
    localparam logic [4:0] ADDR_AL_DAYDATE = 5'h0_B;
    localparam logic [4:0] ADDR_WDOG_LOW = 5'h0_C;
    localparam logic [4:0] ADDR_WDOG_HIGH = 5'h0_D;
    localparam logic [4:0] ADDR_EVENT_FLAGS = 5'h0_E;
    localparam logic [4:0] ADDR_CONTROL_SECOND = 5'h0_F;
    // field positions
    localparam int ALARM_MASK_BIT = 7;
    localparam int DAY_DATE_SEL_BIT = 6;
    localparam int FLAG_ALARM_BIT = 0;
    localparam int FLAG_WDOG_BIT = 1;
    localparam int FLAG_IRQ_BIT = 2;
    localparam int CTL_EXT_UPDATE_BIT = 7;
    localparam int CTL_OSC_EN_N_BIT = 6;
    localparam int CTL_ALARM_IRQ_EN_BIT = 5;
    localparam int CTL_ALARM_PWR_EN_BIT = 4;
    localparam int CTL_WDOG_OUT_EN_BIT = 3;
    localparam int CTL_WDOG_STEER_BIT = 2;
    localparam int CTL_XTAL_LOAD_BIT = 1;
    // reset values: ext update on, all other control bits zero
    localparam logic [7:0] CONTROL_RESET = 8'h8_0;
    localparam logic [7:0] ZERO_BYTE = 8'h0_0;
    // timing
    localparam int CLK_HZ = 25_000_000;
    localparam int TICK_WDOG_MS = 10;
    localparam int WDOG_TICK_CYCLES = CLK_HZ / 1000 * TICK_WDOG_MS;
    localparam int RESET_MIN_MS = 40;
    localparam int RESET_MAX_MS = 200;
    localparam int RESET_CYCLES_DFLT = (CLK_HZ / 1000) * ((RESET_MIN_MS + RESET_MAX_MS) / 2);
    localparam int SECOND_CYCLES_DFLT = CLK_HZ;
    // alarm match modes
    typedef enum logic [2:0] {
        RAWC_AL_EVERY = 3'b000,
        RAWC_AL_SEC = 3'b001,
        RAWC_AL_MINSEC = 3'b010,
        RAWC_AL_HMS = 3'b011,
        RAWC_AL_DATE = 3'b100,
        RAWC_AL_DAY = 3'b101
    } rawc_alarm_mode_t;
endpackage : rawc_pkg

// ==== rtl/rawc_top.sv ====
// control logic of a battery-backed rtc: access gate, reset stretch, alarm, watchdog, flags
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - below power-fail, all bus accesses refused, inputs ignored, data outputs tri-stated
// - reset out pulled low at power fail, held 40-200 ms after supply returns
// - oscillator runs only while osc_enable_n is 0
// - clearing ext_update_enable freezes visible time, internal count continues
// - setting ext_update_enable resumes visible updates within one second
// - setting ext_update_enable copies host-written time into internal counters
// - crystal load select bit chooses 6 pF or 12.5 pF setting
// - alarm settings live in byte registers 08h through 0Bh
// - masks decode to every-second, seconds, min-sec, hms, date or weekday match
// - undefined mask combinations fire the alarm every second
// - matching fields set alarm_flag regardless of output enables
// - alarm_flag drives irq if irq-enabled, power_on if power-enabled
// - watchdog period from two bcd bytes 0Ch/0Dh in 10 ms steps
// - timeout without host write sets wdog_flag even with outputs disabled
// - timeout, output enabled, steer 0: set flags and pull irq low
// - timeout, output enabled, steer 1: flag, reset pulse, clear output enable
// - after each timeout the watchdog reloads and restarts
// - each host watchdog register write reloads and restarts the period
// - both watchdog bytes zero disables the watchdog
// - watchdog starts disabled at power-up
// - reading flags at 0Eh clears them on address change or strobe rise
// - irq released once irq_pending_flag is cleared
// - read while select and output enable low and write high; write while select and write both low
// - power-up forces osc, irq enables, watchdog enable and steer to zero
module rawc_top #(
    parameter int RESET_CYCLES = rawc_pkg::RESET_CYCLES_DFLT,
    parameter int SECOND_CYCLES = rawc_pkg::SECOND_CYCLES_DFLT,
    parameter int WDOG_TICK = rawc_pkg::WDOG_TICK_CYCLES
) (
    input wire logic I_SYS_CLK,
    input wire logic I_RESETN,
    input wire logic I_POWER_OK,
    input wire logic I_CS_N,
    input wire logic I_OE_N,
    input wire logic I_WE_N,
    input wire logic [4:0] I_ADDR,
    input wire logic [7:0] I_DQ,
    output logic [7:0] O_DQ,
    output logic O_DQ_OE_N,
    output logic O_IRQ_N,
    output logic O_POWER_ON_N,
    output logic O_RESET_OUT_N,
    output logic O_OSC_RUN,
    output logic O_XTAL_LOAD_SEL
);
    // bus sampling state
    logic cs_n_q, oe_n_q, we_n_q;
    logic [4:0] addr_q;
    logic wr_act_q;
    logic clr_armed_q, clr_armed_d;
    // register state
    logic [7:0] al_q [4];
    logic [7:0] al_d [4];
    logic [7:0] wd_lo_q, wd_lo_d, wd_hi_q, wd_hi_d;
    logic [7:0] ctl_q, ctl_d;
    logic alarm_flag_q, alarm_flag_d, wdog_flag_q, wdog_flag_d, irq_flag_q, irq_flag_d;
    // time: internal counters and host-visible copy
    logic [7:0] in_t_q [5];
    logic [7:0] in_t_d [5];
    logic [7:0] ex_t_q [5];
    logic [7:0] ex_t_d [5];
    logic [31:0] sec_cnt_q, sec_cnt_d;
    logic [31:0] wd_tick_q, wd_tick_d;
    logic [15:0] wd_cnt_q, wd_cnt_d;
    logic [31:0] rst_cnt_q, rst_cnt_d;
    logic [7:0] dq_q, dq_d;
    logic dq_oe_n_q, dq_oe_n_d;
    logic irq_n_q, pwr_n_q, rst_n_q, osc_run_q;
    logic sec_tick, wd_timeout, wd_write, wr_start, flag_read, flag_clear;
    logic al_match;
    rawc_pkg::rawc_alarm_mode_t al_mode;

    // bcd increment with wrap to a floor value
    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] top,
                                           input logic [7:0] floor_v);
        logic [7:0] r;
        r = v;
        if (v >= top) begin
            r = floor_v;
        end else if (v[3:0] == 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction : bcd_inc

    // 4-digit bcd decrement, wraps zero to 9999
    function automatic logic [15:0] bcd_dec4(input logic [15:0] v);
        logic [15:0] r;
        int i;
        logic brw;
        r = v;
        brw = 1'b1;
        for (i = 0; i < 4; i++) begin
            if (brw) begin
                if (r[i*4 +: 4] == 4'h0) begin
                    r[i*4 +: 4] = 4'h9;
                end else begin
                    r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
                    brw = 1'b0;
                end
            end
        end
        return r;
    endfunction : bcd_dec4

    // bus strobes are ignored entirely while supply is below trip point
    logic acc_ok;
    assign acc_ok = I_POWER_OK;
    assign wr_start = acc_ok && !cs_n_q && !we_n_q && !wr_act_q;
    assign wd_write = wr_start && (addr_q == rawc_pkg::ADDR_WDOG_LOW ||
                                   addr_q == rawc_pkg::ADDR_WDOG_HIGH);
    assign flag_read = acc_ok && !cs_n_q && we_n_q && !oe_n_q &&
                       addr_q == rawc_pkg::ADDR_EVENT_FLAGS;
    // clear fires when the armed read ends by address change or strobe rise
    assign flag_clear = clr_armed_q && (I_CS_N || I_OE_N || I_ADDR != addr_q ||
                                        !acc_ok);
    assign sec_tick = !ctl_q[rawc_pkg::CTL_OSC_EN_N_BIT] &&
                      sec_cnt_q == 32'(SECOND_CYCLES - 1);
    assign wd_timeout = (wd_lo_q != rawc_pkg::ZERO_BYTE || wd_hi_q != rawc_pkg::ZERO_BYTE) &&
                        wd_tick_q == 32'(WDOG_TICK - 1) && wd_cnt_q == 16'h0_001 &&
                        !wd_write;

    // alarm mode decode from masks
    always_comb begin
        unique case ({al_q[3][rawc_pkg::ALARM_MASK_BIT], al_q[2][rawc_pkg::ALARM_MASK_BIT],
                      al_q[1][rawc_pkg::ALARM_MASK_BIT], al_q[0][rawc_pkg::ALARM_MASK_BIT]})
            4'b1110: al_mode = rawc_pkg::RAWC_AL_SEC;
            4'b1100: al_mode = rawc_pkg::RAWC_AL_MINSEC;
            4'b1000: al_mode = rawc_pkg::RAWC_AL_HMS;
            4'b0000: al_mode = al_q[3][rawc_pkg::DAY_DATE_SEL_BIT] ?
                               rawc_pkg::RAWC_AL_DAY : rawc_pkg::RAWC_AL_DATE;
            default: al_mode = rawc_pkg::RAWC_AL_EVERY;
        endcase
    end

    // field compare against the internal count, evaluated on each second step
    always_comb begin
        logic s_eq, m_eq, h_eq;
        s_eq = in_t_q[0] == {1'b0, al_q[0][6:0]};
        m_eq = in_t_q[1] == {1'b0, al_q[1][6:0]};
        h_eq = in_t_q[2] == {2'b00, al_q[2][5:0]};
        unique case (al_mode)
            rawc_pkg::RAWC_AL_EVERY: al_match = 1'b1;
            rawc_pkg::RAWC_AL_SEC: al_match = s_eq;
            rawc_pkg::RAWC_AL_MINSEC: al_match = s_eq && m_eq;
            rawc_pkg::RAWC_AL_HMS: al_match = s_eq && m_eq && h_eq;
            rawc_pkg::RAWC_AL_DATE: al_match = s_eq && m_eq && h_eq &&
                                               in_t_q[4] == {2'b00, al_q[3][5:0]};
            rawc_pkg::RAWC_AL_DAY: al_match = s_eq && m_eq && h_eq &&
                                              in_t_q[3] == {5'h00, al_q[3][2:0]};
            default: al_match = 1'b0;
        endcase
    end

    // next state of registers, counters and flags
    always_comb begin
        logic ext_up;
        ext_up = ctl_q[rawc_pkg::CTL_EXT_UPDATE_BIT];
        al_d = al_q;
        wd_lo_d = wd_lo_q;
        wd_hi_d = wd_hi_q;
        ctl_d = ctl_q;
        in_t_d = in_t_q;
        ex_t_d = ex_t_q;
        sec_cnt_d = sec_cnt_q;
        wd_tick_d = wd_tick_q;
        wd_cnt_d = wd_cnt_q;
        alarm_flag_d = alarm_flag_q;
        wdog_flag_d = wdog_flag_q;
        irq_flag_d = irq_flag_q;
        clr_armed_d = clr_armed_q;
        // time base runs only while oscillator enabled
        if (!ctl_q[rawc_pkg::CTL_OSC_EN_N_BIT]) begin
            sec_cnt_d = sec_tick ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
        end
        if (sec_tick) begin
            in_t_d[0] = bcd_inc(in_t_q[0], 8'h5_9, 8'h0_0);
            if (in_t_q[0] == 8'h5_9) begin
                in_t_d[1] = bcd_inc(in_t_q[1], 8'h5_9, 8'h0_0);
                if (in_t_q[1] == 8'h5_9) begin
                    in_t_d[2] = bcd_inc(in_t_q[2], 8'h2_3, 8'h0_0);
                    if (in_t_q[2] == 8'h2_3) begin
                        in_t_d[3] = bcd_inc(in_t_q[3], 8'h0_7, 8'h0_1);
                        in_t_d[4] = bcd_inc(in_t_q[4], 8'h3_1, 8'h0_1);
                    end
                end
            end
            if (al_match) begin
                alarm_flag_d = 1'b1;
            end
        end
        // visible copy follows internal count only while updates enabled
        if (ext_up) begin
            ex_t_d = in_t_d;
        end
        // host write decode
        if (wr_start) begin
            unique case (addr_q)
                rawc_pkg::ADDR_SEC, rawc_pkg::ADDR_MIN, rawc_pkg::ADDR_HOUR,
                rawc_pkg::ADDR_DAY, rawc_pkg::ADDR_DATE: ex_t_d[addr_q[2:0]] = I_DQ;
                rawc_pkg::ADDR_AL_SEC, rawc_pkg::ADDR_AL_MIN, rawc_pkg::ADDR_AL_HOUR,
                rawc_pkg::ADDR_AL_DAYDATE: al_d[addr_q[1:0]] = I_DQ;
                rawc_pkg::ADDR_WDOG_LOW: wd_lo_d = I_DQ;
                rawc_pkg::ADDR_WDOG_HIGH: wd_hi_d = I_DQ;
                rawc_pkg::ADDR_CONTROL_SECOND: begin
                    ctl_d = I_DQ;
                    if (I_DQ[rawc_pkg::CTL_EXT_UPDATE_BIT] && !ext_up) begin
                        in_t_d = ex_t_q;
                        sec_cnt_d = 32'h0000_0000;
                    end
                end
                default: ;
            endcase
        end
        // watchdog: reload on write or timeout, else count 10 ms steps
        if (wd_write || wd_timeout) begin
            wd_tick_d = 32'h0000_0000;
            wd_cnt_d = wd_write ? (addr_q == rawc_pkg::ADDR_WDOG_LOW ?
                {wd_hi_q, I_DQ} : {I_DQ, wd_lo_q}) : {wd_hi_q, wd_lo_q};
        end else if (wd_cnt_q != 16'h0_000) begin
            if (wd_tick_q == 32'(WDOG_TICK - 1)) begin
                wd_tick_d = 32'h0000_0000;
                wd_cnt_d = bcd_dec4(wd_cnt_q);
            end else begin
                wd_tick_d = wd_tick_q + 32'h0000_0001;
            end
        end
        // flag clear by read first, so a same-cycle event wins
        if (flag_read) begin
            clr_armed_d = 1'b1;
        end
        if (flag_clear) begin
            clr_armed_d = 1'b0;
            alarm_flag_d = sec_tick && al_match;
            wdog_flag_d = 1'b0;
            irq_flag_d = 1'b0;
        end
        if (wd_timeout) begin
            wdog_flag_d = 1'b1;
            if (ctl_q[rawc_pkg::CTL_WDOG_OUT_EN_BIT] &&
                !ctl_q[rawc_pkg::CTL_WDOG_STEER_BIT]) begin
                irq_flag_d = 1'b1;
            end
            if (ctl_q[rawc_pkg::CTL_WDOG_OUT_EN_BIT] &&
                ctl_q[rawc_pkg::CTL_WDOG_STEER_BIT]) begin
                ctl_d[rawc_pkg::CTL_WDOG_OUT_EN_BIT] = 1'b0;
            end
        end
        if (alarm_flag_d && ctl_d[rawc_pkg::CTL_ALARM_IRQ_EN_BIT]) begin
            irq_flag_d = irq_flag_d | (sec_tick && al_match);
        end
    end

    // reset stretch: load on power fail or steered watchdog timeout
    always_comb begin
        if (!I_POWER_OK) begin
            rst_cnt_d = 32'(RESET_CYCLES);
        end else if (wd_timeout && ctl_q[rawc_pkg::CTL_WDOG_OUT_EN_BIT] &&
                     ctl_q[rawc_pkg::CTL_WDOG_STEER_BIT]) begin
            rst_cnt_d = 32'(RESET_CYCLES);
        end else if (rst_cnt_q != 32'h0000_0000) begin
            rst_cnt_d = rst_cnt_q - 32'h0000_0001;
        end else begin
            rst_cnt_d = rst_cnt_q;
        end
    end

    // read data path, tri-stated outside a powered read
    always_comb begin
        dq_oe_n_d = !(acc_ok && !I_CS_N && I_WE_N && !I_OE_N);
        unique case (I_ADDR)
            rawc_pkg::ADDR_SEC, rawc_pkg::ADDR_MIN, rawc_pkg::ADDR_HOUR,
            rawc_pkg::ADDR_DAY, rawc_pkg::ADDR_DATE: dq_d = ex_t_q[I_ADDR[2:0]];
            rawc_pkg::ADDR_AL_SEC, rawc_pkg::ADDR_AL_MIN, rawc_pkg::ADDR_AL_HOUR,
            rawc_pkg::ADDR_AL_DAYDATE: dq_d = al_q[I_ADDR[1:0]];
            rawc_pkg::ADDR_WDOG_LOW: dq_d = wd_lo_q;
            rawc_pkg::ADDR_WDOG_HIGH: dq_d = wd_hi_q;
            rawc_pkg::ADDR_EVENT_FLAGS: dq_d = {5'h00, irq_flag_q, wdog_flag_q, alarm_flag_q};
            rawc_pkg::ADDR_CONTROL_SECOND: dq_d = ctl_q;
            default: dq_d = rawc_pkg::ZERO_BYTE;
        endcase
        if (dq_oe_n_d) begin
            dq_d = rawc_pkg::ZERO_BYTE;
        end
    end

    // all state registers; control bits come up at their power-up defaults
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            cs_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            addr_q <= 5'h0_0;
            wr_act_q <= 1'b0;
            clr_armed_q <= 1'b0;
            al_q <= '{default: 8'h0_0};
            wd_lo_q <= rawc_pkg::ZERO_BYTE;
            wd_hi_q <= rawc_pkg::ZERO_BYTE;
            ctl_q <= rawc_pkg::CONTROL_RESET;
            alarm_flag_q <= 1'b0;
            wdog_flag_q <= 1'b0;
            irq_flag_q <= 1'b0;
            in_t_q <= '{8'h0_0, 8'h0_0, 8'h0_0, 8'h0_1, 8'h0_1};
            ex_t_q <= '{8'h0_0, 8'h0_0, 8'h0_0, 8'h0_1, 8'h0_1};
            sec_cnt_q <= 32'h0000_0000;
            wd_tick_q <= 32'h0000_0000;
            wd_cnt_q <= 16'h0_000;
            rst_cnt_q <= 32'h0000_0000;
            dq_q <= rawc_pkg::ZERO_BYTE;
            dq_oe_n_q <= 1'b1;
            irq_n_q <= 1'b1;
            pwr_n_q <= 1'b1;
            rst_n_q <= 1'b0;
            osc_run_q <= 1'b1; // control reset leaves osc_enable_n at 0
        end else begin
            // select and write strobes ignored during power fail so no stale write fires on return
            cs_n_q <= acc_ok ? I_CS_N : 1'b1;
            oe_n_q <= I_OE_N;
            we_n_q <= acc_ok ? I_WE_N : 1'b1;
            addr_q <= I_ADDR;
            wr_act_q <= acc_ok && !cs_n_q && !we_n_q;
            clr_armed_q <= clr_armed_d;
            al_q <= al_d;
            wd_lo_q <= wd_lo_d;
            wd_hi_q <= wd_hi_d;
            ctl_q <= ctl_d;
            alarm_flag_q <= alarm_flag_d;
            wdog_flag_q <= wdog_flag_d;
            irq_flag_q <= irq_flag_d;
            in_t_q <= in_t_d;
            ex_t_q <= ex_t_d;
            sec_cnt_q <= sec_cnt_d;
            wd_tick_q <= wd_tick_d;
            wd_cnt_q <= wd_cnt_d;
            rst_cnt_q <= rst_cnt_d;
            dq_q <= dq_d;
            dq_oe_n_q <= dq_oe_n_d;
            // irq released as soon as no enabled source is pending
            irq_n_q <= !(acc_ok && (irq_flag_d || (alarm_flag_d &&
                         ctl_d[rawc_pkg::CTL_ALARM_IRQ_EN_BIT])));
            pwr_n_q <= !(alarm_flag_d && ctl_d[rawc_pkg::CTL_ALARM_PWR_EN_BIT]);
            rst_n_q <= I_POWER_OK && rst_cnt_d == 32'h0000_0000;
            osc_run_q <= !ctl_d[rawc_pkg::CTL_OSC_EN_N_BIT];
        end
    end

    assign O_DQ = dq_q;
    assign O_DQ_OE_N = dq_oe_n_q;
    assign O_IRQ_N = irq_n_q;
    assign O_POWER_ON_N = pwr_n_q;
    assign O_RESET_OUT_N = rst_n_q;
    assign O_OSC_RUN = osc_run_q;
    assign O_XTAL_LOAD_SEL = ctl_q[rawc_pkg::CTL_XTAL_LOAD_BIT];

    // checks
    chk_powerfail_tristate: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        !I_POWER_OK |=> O_DQ_OE_N) else $error("data driven during power fail");
    chk_reset_on_fail: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        !I_POWER_OK |=> !O_RESET_OUT_N) else $error("reset not low on power fail");
    chk_wdog_flag_set: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        wd_timeout |=> wdog_flag_q) else $error("timeout without wdog flag");
    chk_wdog_irq_path: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        wd_timeout && ctl_q[3] && !ctl_q[2] && I_POWER_OK |=> irq_flag_q && !O_IRQ_N)
        else $error("steer zero timeout missed irq");
    chk_wdog_rst_path: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        wd_timeout && ctl_q[3] && ctl_q[2] |=> !O_RESET_OUT_N && !ctl_q[3])
        else $error("steer one timeout missed reset");
    chk_wdog_disabled: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        wd_lo_q == 8'h0_0 && wd_hi_q == 8'h0_0 |-> wd_cnt_q == 16'h0_000 && !wd_timeout)
        else $error("disabled watchdog timed out");
    chk_wdog_reload: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        wd_write |=> wd_tick_q == 32'h0000_0000) else $error("write did not reload");
    chk_freeze_visible: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        !ctl_q[7] && !ctl_d[7] && !wr_start |=> $stable(ex_t_q[0]))
        else $error("visible time moved while frozen");
    chk_irq_release: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        !irq_flag_q && !(alarm_flag_q && ctl_q[5]) && !irq_flag_d && !(alarm_flag_d && ctl_d[5])
        |=> O_IRQ_N) else $error("irq held with nothing pending");
    chk_flag_cleared: assert property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        flag_clear && !wd_timeout |=> !wdog_flag_q) else $error("read did not clear");
    cov_wdog_timeout: cover property (@(posedge I_SYS_CLK) disable iff (!I_RESETN) wd_timeout);
    cov_alarm_set: cover property (@(posedge I_SYS_CLK) disable iff (!I_RESETN)
        $rose(alarm_flag_q));
    cov_flag_clear: cover property (@(posedge I_SYS_CLK) disable iff (!I_RESETN) flag_clear);
endmodule : rawc_top
`default_nettype wire

// ==== sim/rawc_host.sv ====
// host processor model on the asynchronous byte-wide register bus
`timescale 1ns/1ns
`default_nettype none
module rawc_host (
    input wire logic i_clk,
    input wire logic [7:0] i_dq,
    input wire logic i_dq_oe_n,
    output logic o_cs_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic [4:0] o_addr,
    output logic [7:0] o_dq
);
    initial begin
        o_cs_n = 1'b1;
        o_oe_n = 1'b1;
        o_we_n = 1'b1;
        o_addr = 5'h1_F;
        o_dq = 8'h0_0;
    end
    // one access: strobes, address and data held three edges, answer taken at the last
    task automatic cyc(input logic wr, input logic [4:0] a, input logic [7:0] d,
                       output logic [8:0] q);
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        o_we_n <= ~wr;
        o_oe_n <= wr;
        o_addr <= a;
        o_dq <= d;
        repeat (3) @(posedge i_clk);
        q = {i_dq_oe_n, i_dq};
        // released lines show the inverse so stale values never pass for live ones
        o_cs_n <= 1'b1;
        o_we_n <= 1'b1;
        o_oe_n <= 1'b1;
        o_addr <= ~a;
        o_dq <= ~d;
        // two idle edges keep back-to-back writes apart
        repeat (2) @(posedge i_clk);
    endtask : cyc
endmodule : rawc_host
`default_nettype wire

// ==== sim/tb_rawc_top.sv ====
// self-checking bench for the rtc alarm and watchdog control block
`timescale 1ns/1ns
`default_nettype none
module tb_rawc_top;
    localparam int RSTC = 20;
    localparam logic [4:0] CTL = rawc_pkg::ADDR_CONTROL_SECOND;
    localparam logic [4:0] FLG = rawc_pkg::ADDR_EVENT_FLAGS;
    localparam logic [4:0] WLO = rawc_pkg::ADDR_WDOG_LOW;
    localparam logic [4:0] SEC = rawc_pkg::ADDR_SEC;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pwr_ok = 1'b1;
    logic cs_n, oe_n, we_n, dq_oe_n, irq_n, pwr_on_n, rst_out_n, osc_run, xtal;
    logic [4:0] addr;
    logic [7:0] dq_w, dq_r, r;
    logic [8:0] seen;
    logic [8:0] notes[$];
    int n_fail = 0;
    int n_compared = 0;
    event got;
    initial forever #20 clk = ~clk;
    rawc_top #(.RESET_CYCLES(RSTC), .SECOND_CYCLES(50), .WDOG_TICK(5)) dut (
        .I_SYS_CLK(clk), .I_RESETN(rst_n), .I_POWER_OK(pwr_ok), .I_CS_N(cs_n),
        .I_OE_N(oe_n), .I_WE_N(we_n), .I_ADDR(addr), .I_DQ(dq_w), .O_DQ(dq_r),
        .O_DQ_OE_N(dq_oe_n), .O_IRQ_N(irq_n), .O_POWER_ON_N(pwr_on_n),
        .O_RESET_OUT_N(rst_out_n), .O_OSC_RUN(osc_run), .O_XTAL_LOAD_SEL(xtal));
    rawc_host host (.i_clk(clk), .i_dq(dq_r), .i_dq_oe_n(dq_oe_n), .o_cs_n(cs_n),
        .o_oe_n(oe_n), .o_we_n(we_n), .o_addr(addr), .o_dq(dq_w));
    task automatic chk(input logic [8:0] s, input logic [8:0] e);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [8:0] q;
        host.cyc(1'b1, a, d, q);
    endtask : wr
    // the note goes on the queue before the access; the watcher compares the answer
    task automatic rd(input logic [4:0] a, input logic [8:0] e, input logic [8:0] m);
        logic [8:0] q;
        notes.push_back(e & m);
        host.cyc(1'b0, a, 8'h0_0, q);
        seen = q & m;
        -> got;
    endtask : rd
    always @(got) chk(seen, notes.pop_front());
    // bounded wait for a pin level; running out is a mismatch
    task automatic wait_lvl(ref logic s, input logic v, input int n);
        for (int i = 0; i < n && s !== v; i++) @(posedge clk);
        chk({8'h0_0, s}, {8'h0_0, v});
    endtask : wait_lvl
    task automatic conclude();
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude
    initial begin
        #(40 * 12000);
        n_fail++;
        conclude();
    end
    initial begin
        void'($urandom(32'h1fcd_d943));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (300) @(posedge clk);
        rd(CTL, 9'h0_80, 9'h1_FF);
        rd(FLG, 9'h0_00, 9'h1_06);
        // alarm bytes with every mask set, so the alarm fires each second
        for (int i = 0; i < 4; i++) begin
            r = {1'b1, 3'($urandom % 3), 4'($urandom % 10)};
            wr(5'h0_8 + 5'(i), r);
            rd(5'h0_8 + 5'(i), {1'b0, r}, 9'h1_FF);
        end
        rd(FLG, 9'h0_00, 9'h1_00);
        repeat (60) @(posedge clk);
        rd(FLG, 9'h0_01, 9'h1_01);
        rd(FLG, 9'h0_00, 9'h1_01);
        wr(5'h0_A, 8'h0_0);
        rd(FLG, 9'h0_00, 9'h1_00);
        repeat (60) @(posedge clk);
        rd(FLG, 9'h0_01, 9'h1_01);
        wr(CTL, 8'hA_0);
        wait_lvl(irq_n, 1'b0, 60);
        chk({8'h0_0, pwr_on_n}, 9'h0_01);
        wr(CTL, 8'h9_0);
        wait_lvl(pwr_on_n, 1'b0, 60);
        wr(CTL, 8'h8_0);
        rd(FLG, 9'h0_04, 9'h1_04);
        chk({8'h0_0, irq_n}, 9'h0_01);
        // seconds-only match on a second far ahead must stay quiet
        wr(5'h0_A, 8'h8_0);
        wr(5'h0_8, 8'h5_9);
        rd(FLG, 9'h0_00, 9'h1_00);
        repeat (120) @(posedge clk);
        rd(FLG, 9'h0_00, 9'h1_01);
        // watchdog of 20 ticks (bcd byte 20h) with the interrupt route
        wr(rawc_pkg::ADDR_WDOG_HIGH, 8'h0_0);
        wr(WLO, 8'h2_0);
        wr(CTL, 8'h8_8);
        wait_lvl(irq_n, 1'b0, 120);
        rd(FLG, 9'h0_06, 9'h1_06);
        chk({8'h0_0, irq_n}, 9'h0_01);
        repeat (3) begin
            repeat (50) @(posedge clk);
            wr(WLO, 8'h2_0);
        end
        repeat (85) @(posedge clk);
        chk({8'h0_0, irq_n}, 9'h0_01);
        wait_lvl(irq_n, 1'b0, 30);
        wr(WLO, 8'h0_0);
        rd(FLG, 9'h0_00, 9'h1_00);
        repeat (300) @(posedge clk);
        rd(FLG, 9'h0_00, 9'h1_06);
        wr(WLO, 8'h0_2);
        wr(CTL, 8'h8_C);
        wait_lvl(rst_out_n, 1'b0, 40);
        rd(CTL, 9'h0_84, 9'h1_FF);
        wait_lvl(rst_out_n, 1'b1, RSTC + 5);
        wr(WLO, 8'h0_0);
        wr(CTL, 8'hC_2);
        chk({7'h0_0, osc_run, xtal}, 9'h0_01);
        wr(CTL, 8'h8_0);
        chk({7'h0_0, osc_run, xtal}, 9'h0_02);
        // freeze, set the seconds, then copy them into the running count
        wr(CTL, 8'h0_0);
        wr(SEC, 8'h1_0);
        repeat (150) @(posedge clk);
        rd(SEC, 9'h0_10, 9'h1_FF);
        wr(CTL, 8'h8_0);
        rd(SEC, 9'h0_10, 9'h1_FE);
        repeat (100) @(posedge clk);
        rd(SEC, 9'h0_12, 9'h1_FE);
        pwr_ok <= 1'b0;
        repeat (3) @(posedge clk);
        chk({8'h0_0, rst_out_n}, 9'h0_00);
        wr(CTL, 8'hC_0);
        rd(CTL, 9'h1_00, 9'h1_00);
        pwr_ok <= 1'b1;
        repeat (RSTC - 3) @(posedge clk);
        chk({8'h0_0, rst_out_n}, 9'h0_00);
        wait_lvl(rst_out_n, 1'b1, 10);
        rd(CTL, 9'h0_80, 9'h1_FF);
        conclude();
    end
endmodule : tb_rawc_top
`default_nettype wire
